// [logic/wdps_defs.svh]
// constants of the watchdog with shared divider: offsets, fields, resets, timing
// assumes inclusion by bare name; definitions only
// Contract
// R1: watchdog counts its own RC oscillator ticks
// R2: timeout resets device, or wakes from sleep
// R3: watchdog reset clears timeout flag, status bit4
// R4: fuse at zero disables watchdog permanently
// R5: one 8-bit divider, timer or watchdog
// R6: option bits 3:0 choose owner and ratio
// R7: base period 18 ms, up to 1:128
// R8: clear command zeroes count and owned divider
// R9: sleep zeroes count and owned divider
// R10: option loads all ones on every reset
// R11: option bits 7:6 read as zero
// R12: watchdog ratio is two to the select
`ifndef WDPS_DEFS_SVH
`define WDPS_DEFS_SVH

// ****************************************
// register indices, byte address is index times four
// ****************************************
`define WDPS_IDX_STATUS   6'h03
`define WDPS_IDX_OPTION   6'h04
`define WDPS_IDX_CMD      6'h05
`define WDPS_IDX_IRQST    6'h06
`define WDPS_IDX_IRQMSK   6'h07

// ****************************************
// field positions
// ****************************************
`define WDPS_ST_TIMEOUT   4
`define WDPS_ST_PWRDOWN   3
`define WDPS_OPT_ASSIGN   3
`define WDPS_CMD_CLEAR    0
`define WDPS_CMD_SLEEP    1
`define WDPS_CMD_WAKE     2
`define WDPS_EVT_RUN      0
`define WDPS_EVT_WAKE     1

// ****************************************
// reset values and masks
// ****************************************
`define WDPS_STATUS_RST   8'h18
`define WDPS_STATUS_WMASK 8'hE7
`define WDPS_OPTION_RST   6'h3F
`define WDPS_RESP_OKAY    2'h0
`define WDPS_RESP_SLVERR  2'h2

// ****************************************
// timing
// ****************************************
`define WDPS_TIMEOUT_MS   18
`define WDPS_RC_PERIOD_NS 1000
`define WDPS_BASE_TICKS   ((`WDPS_TIMEOUT_MS * 1000000) / `WDPS_RC_PERIOD_NS)

`endif

// [logic/wdps_pkg.sv]
// types of the watchdog with shared divider
// assumes nothing beyond the compile order
package wdps_pkg;

    // ****************************************
    // core modes
    // ****************************************
    typedef enum logic {
        WDPS_RUN,
        WDPS_SLEEP
    } wdps_mode_e;

    // ****************************************
    // top-level state
    // ****************************************
    typedef struct packed {
        wdps_mode_e  mode;
        logic        fuseEn;
        logic [15:0] baseCnt;
        logic [5:0]  option;
        logic [7:0]  status;
        logic [1:0]  evt;
        logic [1:0]  mask;
        logic        devRst;
        logic        wake;
        logic        awHave;
        logic [5:0]  awIdx;
        logic        wHave;
        logic [7:0]  wData;
        logic        wStb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [7:0]  rdata;
        logic [1:0]  rresp;
        logic        rdOpt;
    } wdps_state_s;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } wdps_sync_s;

    typedef struct packed {
        logic [7:0] cnt;
    } wdps_div_s;

endpackage : wdps_pkg

// [logic/wdps_sync.sv]
// three-stage pin synchroniser with agreed-level edge pulses
// assumes an asynchronous pin and the mclk domain
`timescale 1ns/10ps
`default_nettype none
module wdps_sync #(
    parameter logic INIT = 1'b0
) (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic pinIn,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    wdps_pkg::wdps_sync_s st;
    wdps_pkg::wdps_sync_s n;

    // level moves only when stages two and three agree
    always_comb begin
        n = st;
        n.s1 = pinIn;
        n.s2 = st.s1;
        n.s3 = st.s2;
        if (st.s2 == st.s3) begin
            n.level = st.s3;
        end
        if (!rstn) begin
            n = '{s1: INIT, s2: INIT, s3: INIT, level: INIT};
        end
    end

    always_ff @(posedge mclk) begin
        st <= n;
    end

    // one-cycle pulses on an agreed change
    assign level = st.level;
    assign rise  = st.s2 & st.s3 & ~st.level;
    assign fall  = ~st.s2 & ~st.s3 & st.level;

endmodule : wdps_sync
`default_nettype wire

// [logic/wdps_divider.sv]
// shared 8-bit divider, passes every 2^shift-th input tick
// assumes ticks and clear from the mclk domain
`timescale 1ns/10ps
`default_nettype none
module wdps_divider (
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic       tickIn,
    input  wire logic       clear,
    input  wire logic [3:0] shift,
    output logic            tickOut,
    output logic [7:0]      count
);
    wdps_pkg::wdps_div_s st;
    wdps_pkg::wdps_div_s n;

    // low-bit mask for a ratio of two to the shift
    function automatic logic [7:0] ratioMask(input logic [3:0] sh);
        logic [8:0] m;
        m = (9'h001 << sh) - 9'h001;
        return m[7:0];
    endfunction : ratioMask

    // counter advances per input tick, clear wins
    always_comb begin
        n = st;
        if (!rstn || clear) begin
            n.cnt = 8'h00;
        end else if (tickIn) begin
            n.cnt = st.cnt + 8'h01;
        end
    end

    always_ff @(posedge mclk) begin
        st <= n;
    end

    // output tick when the selected low bits roll over
    assign tickOut = tickIn & ~clear & ((st.cnt & ratioMask(shift)) == ratioMask(shift)); // [R5]
    assign count   = st.cnt;

endmodule : wdps_divider
`default_nettype wire

// [logic/wdps_top.sv]
// watchdog on its own RC oscillator, shared timer/watchdog divider, AXI4-Lite registers
// assumes rcOscIn and extClearN are asynchronous pins, t0TickIn is an mclk pulse
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "wdps_defs.svh"
module wdps_top #(
    parameter int unsigned BASE_TICKS = `WDPS_BASE_TICKS
) (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        rcOscIn,
    input  wire logic        extClearN,
    input  wire logic        watchdogEnableFuse,
    input  wire logic        t0TickIn,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [7:0]  awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [7:0]  araddr,
    input  wire logic [2:0]  arprot,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             timerZeroTick,
    output logic             deviceReset,
    output logic             wakeFromSleep,
    output logic             sleeping,
    output logic             irq
);
    // ****************************************
    // state and decode
    // ****************************************
    wdps_pkg::wdps_state_s st;
    wdps_pkg::wdps_state_s n;

    logic       rcRise;
    logic       mclrFall;
    logic       divTick;
    logic [7:0] divCount;
    logic       divider_assign_bit;
    logic [3:0] divShift;
    logic       wrCommit;
    logic       cmdWrite;
    logic       cmdClear;
    logic       sleepEnter;
    logic       cmdWake;
    logic       clearAny;
    logic       baseWrap;
    logic       wdtTimeout;
    logic       divClear;
    logic [5:0] arIdx;

    // mapped register index
    function automatic logic isMapped(input logic [5:0] idx);
        return (idx >= `WDPS_IDX_STATUS) && (idx <= `WDPS_IDX_IRQMSK);
    endfunction : isMapped

    // read mux, option upper bits read zero
    function automatic logic [7:0] readMux(input logic [5:0] idx, input wdps_pkg::wdps_state_s s);
        case (idx)
            `WDPS_IDX_STATUS: readMux = s.status;
            `WDPS_IDX_OPTION: readMux = {2'b00, s.option}; // [R11]
            `WDPS_IDX_IRQST:  readMux = {6'h00, s.evt};
            `WDPS_IDX_IRQMSK: readMux = {6'h00, s.mask};
            default:          readMux = 8'h00;
        endcase
    endfunction : readMux

    // ****************************************
    // pins and divider
    // ****************************************
    wdps_sync #(.INIT(1'b0)) uRcSync (
        .mclk  (mclk),
        .rstn  (rstn),
        .pinIn (rcOscIn),
        .level (),
        .rise  (rcRise),
        .fall  ()
    );

    wdps_sync #(.INIT(1'b1)) uClrSync (
        .mclk  (mclk),
        .rstn  (rstn),
        .pinIn (extClearN),
        .level (),
        .rise  (),
        .fall  (mclrFall)
    );

    // owner and ratio from option bits 3:0
    assign divider_assign_bit      = st.option[`WDPS_OPT_ASSIGN];                                // [R6]
    assign divShift = divider_assign_bit ? {1'b0, st.option[2:0]} : {1'b0, st.option[2:0]} + 4'h1; // [R12]

    wdps_divider uDiv (
        .mclk    (mclk),
        .rstn    (rstn),
        .tickIn  (divider_assign_bit ? baseWrap : t0TickIn), // [R5]
        .clear   (divClear),
        .shift   (divShift),
        .tickOut (divTick),
        .count   (divCount)
    );

    // ****************************************
    // command and timeout decode
    // ****************************************
    assign wrCommit   = st.awHave & st.wHave & ~st.bvalid;
    assign cmdWrite   = wrCommit & st.wStb & (st.awIdx == `WDPS_IDX_CMD);
    assign cmdClear   = cmdWrite & st.wData[`WDPS_CMD_CLEAR];
    assign sleepEnter = cmdWrite & st.wData[`WDPS_CMD_SLEEP] & (st.mode == wdps_pkg::WDPS_RUN);
    assign cmdWake    = cmdWrite & st.wData[`WDPS_CMD_WAKE];
    assign clearAny   = cmdClear | sleepEnter | mclrFall;
    assign divClear   = (divider_assign_bit & (cmdClear | sleepEnter)) | mclrFall;                // [R8] [R9]
    assign baseWrap   = st.fuseEn & rcRise & ~clearAny
                        & (st.baseCnt == 16'(BASE_TICKS - 1));                     // [R7]
    assign wdtTimeout = st.fuseEn & (divider_assign_bit ? divTick : baseWrap);                   // [R4]
    assign timerZeroTick = divider_assign_bit ? t0TickIn : divTick;                              // [R5]
    assign arIdx      = araddr[7:2];

    // ****************************************
    // bus handshakes and outputs
    // ****************************************
    assign awready       = ~st.awHave & ~st.bvalid;
    assign wready        = ~st.wHave & ~st.bvalid;
    assign arready       = ~st.rvalid;
    assign bvalid        = st.bvalid;
    assign bresp         = st.bresp;
    assign rvalid        = st.rvalid;
    assign rdata         = {24'h00_0000, st.rdata};
    assign rresp         = st.rresp;
    assign deviceReset   = st.devRst;
    assign wakeFromSleep = st.wake;
    assign sleeping      = (st.mode == wdps_pkg::WDPS_SLEEP);
    assign irq           = |(st.evt & st.mask);

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        n        = st;
        n.devRst = 1'b0;
        n.wake   = 1'b0;
        // bus write: address and data in either order
        if (awvalid && awready) begin
            n.awHave = 1'b1;
            n.awIdx  = awaddr[7:2];
        end
        if (wvalid && wready) begin
            n.wHave = 1'b1;
            n.wData = wdata[7:0];
            n.wStb  = wstrb[0];
        end
        if (st.bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        if (wrCommit) begin
            n.awHave = 1'b0;
            n.wHave  = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = isMapped(st.awIdx) ? `WDPS_RESP_OKAY : `WDPS_RESP_SLVERR;
            if (st.wStb) begin
                case (st.awIdx)
                    `WDPS_IDX_STATUS: n.status = (st.wData & `WDPS_STATUS_WMASK)
                                                 | (st.status & ~`WDPS_STATUS_WMASK);
                    `WDPS_IDX_OPTION: n.option = st.wData[5:0];                   // [R6]
                    `WDPS_IDX_IRQMSK: n.mask   = st.wData[1:0];
                    default: ;
                endcase
            end
        end
        // bus read, event status clears on read
        if (st.rvalid && rready) begin
            n.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            n.rvalid = 1'b1;
            n.rresp  = isMapped(arIdx) ? `WDPS_RESP_OKAY : `WDPS_RESP_SLVERR;
            n.rdata  = readMux(arIdx, st);
            n.rdOpt  = (arIdx == `WDPS_IDX_OPTION);
            if (arIdx == `WDPS_IDX_IRQST) begin
                n.evt = 2'b00;
            end
        end
        // base count on RC oscillator ticks only
        if (!st.fuseEn || clearAny || baseWrap) begin
            n.baseCnt = 16'h0000;                                                  // [R4] [R8] [R9]
        end else if (rcRise) begin
            n.baseCnt = st.baseCnt + 16'h0001;                                     // [R1]
        end
        // clear, sleep and wake commands
        if (cmdClear) begin
            n.status[`WDPS_ST_TIMEOUT] = 1'b1;
            n.status[`WDPS_ST_PWRDOWN] = 1'b1;
        end
        if (sleepEnter) begin
            n.mode = wdps_pkg::WDPS_SLEEP;
            n.status[`WDPS_ST_TIMEOUT] = 1'b1;
            n.status[`WDPS_ST_PWRDOWN] = 1'b0;
        end
        if (cmdWake && st.mode == wdps_pkg::WDPS_SLEEP) begin
            n.mode = wdps_pkg::WDPS_RUN;
        end
        // timeout: device reset or wake-up reset
        case (st.mode)
            wdps_pkg::WDPS_RUN: begin
                if (wdtTimeout) begin
                    n.devRst = 1'b1;                                               // [R2]
                    n.status[`WDPS_ST_PWRDOWN] = 1'b1;
                    n.evt[`WDPS_EVT_RUN] = 1'b1;
                end
            end
            wdps_pkg::WDPS_SLEEP: begin
                if (wdtTimeout) begin
                    n.devRst = 1'b1;                                               // [R2]
                    n.wake   = 1'b1;
                    n.mode   = wdps_pkg::WDPS_RUN;
                    n.evt[`WDPS_EVT_WAKE] = 1'b1;
                end
            end
            default: n.mode = wdps_pkg::WDPS_RUN;
        endcase
        if (wdtTimeout) begin
            n.status[`WDPS_ST_TIMEOUT] = 1'b0;                                     // [R3]
            n.option = `WDPS_OPTION_RST;                                           // [R10]
        end
        // external master clear
        if (mclrFall) begin
            n.option = `WDPS_OPTION_RST;                                           // [R10]
            n.mode   = wdps_pkg::WDPS_RUN;
        end
        // power-on reset, fuse captured while held
        if (!rstn) begin
            n        = '0;
            n.mode   = wdps_pkg::WDPS_RUN;
            n.fuseEn = watchdogEnableFuse;                                         // [R4]
            n.status = `WDPS_STATUS_RST;
            n.option = `WDPS_OPTION_RST;                                           // [R10]
        end
    end

    always_ff @(posedge mclk) begin
        st <= n;
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    property p_fuse_off;
        !st.fuseEn |-> !deviceReset && st.baseCnt == 16'h0000;
    endproperty
    a_fuse_off: assert property (p_fuse_off) else $error("reset with watchdog fused off"); // [R4]

    property p_count_src;
        $changed(st.baseCnt) |-> $past(rcRise || clearAny || !st.fuseEn);
    endproperty
    a_count_src: assert property (p_count_src) else $error("count moved without a tick"); // [R1]

    property p_flag_clear;
        deviceReset |-> !st.status[`WDPS_ST_TIMEOUT];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("timeout flag set after reset"); // [R3]

    property p_option_ones;
        deviceReset || $past(mclrFall) |-> st.option == `WDPS_OPTION_RST;
    endproperty
    a_option_ones: assert property (p_option_ones) else $error("option not all ones"); // [R10]

    property p_opt_upper;
        rvalid && st.rdOpt |-> rdata[7:6] == 2'b00;
    endproperty
    a_opt_upper: assert property (p_opt_upper) else $error("option upper bits not zero"); // [R11]

    property p_clear_zero;
        cmdClear |=> st.baseCnt == 16'h0000 && (!$past(divider_assign_bit) || divCount == 8'h00);
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("clear left count"); // [R8]

    property p_sleep_zero;
        sleepEnter |=> sleeping && st.baseCnt == 16'h0000 && !st.status[`WDPS_ST_PWRDOWN];
    endproperty
    a_sleep_zero: assert property (p_sleep_zero) else $error("sleep entry wrong"); // [R9]

    property p_wake_src;
        wakeFromSleep |-> deviceReset && $past(sleeping) && !sleeping;
    endproperty
    a_wake_src: assert property (p_wake_src) else $error("wake reset not from sleep"); // [R2]

    property p_base_period;
        deviceReset && !$past(divider_assign_bit) |-> $past(st.baseCnt) == 16'(BASE_TICKS - 1);
    endproperty
    a_base_period: assert property (p_base_period) else $error("base period wrong"); // [R7]

    property p_owner;
        divider_assign_bit |-> timerZeroTick == t0TickIn;
    endproperty
    a_owner: assert property (p_owner) else $error("timer divided while watchdog owns"); // [R5]

    property p_run_reset;
        deviceReset && !wakeFromSleep |-> !$past(sleeping) ##1 !deviceReset;
    endproperty
    a_run_reset: assert property (p_run_reset) else $error("run reset not one pulse"); // [R2]

    // a clear command cycle never lets a time-out through
    property p_clear_quiet;
        cmdClear |=> !deviceReset;
    endproperty
    a_clear_quiet: assert property (p_clear_quiet) else $error("reset despite clear"); // [R8]

    property p_evt_set;
        deviceReset |-> st.evt[`WDPS_EVT_RUN] || st.evt[`WDPS_EVT_WAKE];
    endproperty
    a_evt_set: assert property (p_evt_set) else $error("time-out left no event"); // [R2]

    property p_run_flags;
        deviceReset && !wakeFromSleep |-> st.status[`WDPS_ST_PWRDOWN];
    endproperty
    a_run_flags: assert property (p_run_flags) else $error("run reset lost flag"); // [R2]

    property p_timer_src;
        !divider_assign_bit && timerZeroTick |-> t0TickIn;
    endproperty
    a_timer_src: assert property (p_timer_src) else $error("timer tick without input"); // [R5]

    property p_sleep_hold;
        sleeping && !wdtTimeout && !cmdWake && !mclrFall |=> sleeping;
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("sleep left without cause"); // [R9]

    c_run_reset:  cover property (deviceReset && !wakeFromSleep);
    c_wake_reset: cover property (wakeFromSleep);
    c_psa_reset:  cover property (deviceReset && divider_assign_bit);
    c_irq:        cover property ($rose(irq));
    c_sleep:      cover property (sleepEnter);

endmodule : wdps_top
`default_nettype wire

// [dv/wdps_top_tb.sv]
// self-checking bench for the watchdog with shared divider, driven over AXI4-Lite
// assumes wdps_defs.svh on the include path and wdps_top compiled before this file
`timescale 1ns/10ps
`default_nettype none
`include "wdps_defs.svh"
module wdps_top_tb;
    localparam int LIMIT = 40000;
    logic        mclk, rstn, rcOscIn, extClearN, fuse, t0TickIn;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic        timerZeroTick, deviceReset, wakeFromSleep, sleeping, irq;
    int          badCount, cmpCount, cycles, rstCnt, wakeCnt, tzCnt;
    logic [1:0]  resp;
    logic [3:0]  strb;
    logic [31:0] rd;
    localparam logic [7:0] A_ST  = {`WDPS_IDX_STATUS, 2'b00};
    localparam logic [7:0] A_OPT = {`WDPS_IDX_OPTION, 2'b00};
    localparam logic [7:0] A_CMD = {`WDPS_IDX_CMD, 2'b00};
    localparam logic [7:0] A_EVT = {`WDPS_IDX_IRQST, 2'b00};
    localparam logic [7:0] A_MSK = {`WDPS_IDX_IRQMSK, 2'b00};

    // ****************************************
    // design, clock and pulse counters
    // ****************************************
    wdps_top #(.BASE_TICKS(4)) wdps_top_inst (
        .mclk(mclk), .rstn(rstn), .rcOscIn(rcOscIn), .extClearN(extClearN),
        .watchdogEnableFuse(fuse), .t0TickIn(t0TickIn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(strb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .timerZeroTick(timerZeroTick), .deviceReset(deviceReset),
        .wakeFromSleep(wakeFromSleep), .sleeping(sleeping), .irq(irq)
    );

    // clock at 100 MHz
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // count output pulses and cut a hang short
    always @(posedge mclk) begin
        if (deviceReset === 1'b1) rstCnt++;
        if (wakeFromSleep === 1'b1) wakeCnt++;
        if (timerZeroTick === 1'b1) tzCnt++;
        cycles++;
        if (cycles == LIMIT) begin
            badCount++;
            endSim();
        end
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            badCount++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one write: address and data offered together, each released when taken
    task automatic axiWrite(input logic [7:0] a, input logic [7:0] d);
        awvalid <= 1'b1;
        awaddr  <= a;
        wvalid  <= 1'b1;
        wdata   <= {24'h00_0000, d};
        bready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
        @(posedge mclk);
    endtask : axiWrite

    // one read: address held until taken, rready held until rvalid seen
    task automatic axiRead(input logic [7:0] a);
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd   = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge mclk);
    endtask : axiRead

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        axiRead(a);
        chk(rd, exp);
    endtask : rdChk

    // rc oscillator rises, ten mclk apart
    task automatic rcTicks(input int n);
        repeat (n) begin
            rcOscIn <= 1'b1;
            repeat (5) @(posedge mclk);
            rcOscIn <= 1'b0;
            repeat (5) @(posedge mclk);
        end
    endtask : rcTicks

    task automatic t0Pulses(input int n);
        repeat (n) begin
            t0TickIn <= 1'b1;
            @(posedge mclk);
            t0TickIn <= 1'b0;
            @(posedge mclk);
        end
    endtask : t0Pulses

    // compare reset and wake pulse counts, then start afresh
    task automatic expPulses(input int r, input int w);
        repeat (4) @(posedge mclk);
        chk(32'(rstCnt), 32'(r));
        chk(32'(wakeCnt), 32'(w));
        rstCnt  = 0;
        wakeCnt = 0;
    endtask : expPulses

    task automatic doReset(input logic f);
        rstn <= 1'b0;
        fuse <= f;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        rstCnt  = 0;
        wakeCnt = 0;
    endtask : doReset

    task automatic endSim();
        $display("comparisons %0d mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : endSim

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {rstn, rcOscIn, t0TickIn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {extClearN, fuse} = 2'b11;
        awaddr = '0; araddr = '0; wdata = '0;
        badCount = 0; cmpCount = 0; cycles = 0; tzCnt = 0;
        strb = 4'h1;
        doReset(1'b1);
        // reset values, unimplemented bits and an unmapped place
        rdChk(A_ST, 32'h0000_0018);
        rdChk(A_OPT, 32'h0000_003f);
        axiWrite(A_OPT, 8'hc0);
        rdChk(A_OPT, 32'h0000_0000);
        axiWrite(8'h40, 8'h55);
        chk({30'h0, resp}, 32'h0000_0002);
        rdChk(8'h40, 32'h0000_0000);
        chk({30'h0, resp}, 32'h0000_0002);
        // cleared write strobe answers okay and leaves the register alone
        strb <= 4'h0;
        axiWrite(A_OPT, 8'h15);
        strb <= 4'h1;
        chk({30'h0, resp}, 32'h0000_0000);
        rdChk(A_OPT, 32'h0000_0000);
        // run time-out with timer owning the divider, masked then unmasked
        axiWrite(A_ST, 8'h00);
        rdChk(A_ST, 32'h0000_0018);
        axiWrite(A_OPT, 8'h00);
        axiWrite(A_CMD, 8'h01);
        rcTicks(3);
        expPulses(0, 0);
        rcTicks(1);
        expPulses(1, 0);
        rdChk(A_ST, 32'h0000_0008);
        rdChk(A_OPT, 32'h0000_003f);
        chk({31'h0, irq}, 32'h0000_0000);
        axiWrite(A_MSK, 8'h03);
        chk({31'h0, irq}, 32'h0000_0001);
        rdChk(A_EVT, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0000);
        // every watchdog ratio, two to the select times the base
        for (int r = 0; r < 8; r++) begin
            axiWrite(A_OPT, 8'(8 + r));
            axiWrite(A_CMD, 8'h01);
            rcTicks(4 * (2 ** r) - 1);
            expPulses(0, 0);
            rcTicks(1);
            expPulses(1, 0);
        end
        rdChk(A_EVT, 32'h0000_0001);
        // clear zeroes base count and owned divider
        axiWrite(A_OPT, 8'h09);
        rcTicks(6);
        axiWrite(A_CMD, 8'h01);
        rcTicks(7);
        expPulses(0, 0);
        rcTicks(1);
        expPulses(1, 0);
        rdChk(A_EVT, 32'h0000_0001);
        // sleep restarts the count and time-out wakes the core
        axiWrite(A_OPT, 8'h00);
        rcTicks(2);
        axiWrite(A_CMD, 8'h02);
        chk({31'h0, sleeping}, 32'h0000_0001);
        rdChk(A_ST, 32'h0000_0010);
        rcTicks(3);
        expPulses(0, 0);
        rcTicks(1);
        expPulses(1, 1);
        chk({31'h0, sleeping}, 32'h0000_0000);
        rdChk(A_EVT, 32'h0000_0002);
        rdChk(A_ST, 32'h0000_0000);
        // timer side of the shared divider
        axiWrite(A_OPT, 8'h08);
        tzCnt = 0;
        t0Pulses(8);
        chk(32'(tzCnt), 32'h0000_0008);
        axiWrite(A_OPT, 8'h00);
        tzCnt = 0;
        t0Pulses(8);
        chk(32'(tzCnt), 32'h0000_0004);
        axiWrite(A_OPT, 8'h01);
        tzCnt = 0;
        t0Pulses(8);
        chk(32'(tzCnt), 32'h0000_0002);
        // leave-sleep command ends sleep without any time-out
        axiWrite(A_CMD, 8'h02);
        chk({31'h0, sleeping}, 32'h0000_0001);
        axiWrite(A_CMD, 8'h04);
        chk({31'h0, sleeping}, 32'h0000_0000);
        expPulses(0, 0);
        // external clear reloads the option, no device reset
        axiWrite(A_OPT, 8'h05);
        extClearN <= 1'b0;
        repeat (6) @(posedge mclk);
        extClearN <= 1'b1;
        expPulses(0, 0);
        rdChk(A_OPT, 32'h0000_003f);
        // fuse at zero: no time-out at all
        doReset(1'b0);
        axiWrite(A_OPT, 8'h00);
        rcTicks(9);
        expPulses(0, 0);
        doReset(1'b1);
        rdChk(A_OPT, 32'h0000_003f);
        endSim();
    end
endmodule : wdps_top_tb
`default_nettype wire
